// [hdl/igsc_pkg.sv]
// Package for the ion gauge setpoint and on/off control block.
// Assumes one system clock; all pressures are unsigned linear integers.
package igsc_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;

    // Register byte offsets
    localparam logic [7:0] A_GAS = 8'h00;
    localparam logic [7:0] A_UFAC = 8'h04;
    localparam logic [7:0] A_DELAY = 8'h08;
    localparam logic [7:0] A_PROT = 8'h0C;
    localparam logic [7:0] A_FAST = 8'h10;
    localparam logic [7:0] A_CTL = 8'h14;
    localparam logic [7:0] A_CTLSP = 8'h18;
    localparam logic [7:0] A_HV = 8'h1C;
    localparam logic [7:0] A_SP0 = 8'h20;
    localparam logic [7:0] A_RMODE = 8'h40;

    // Field positions
    localparam int F_MANT_LSB = 0;
    localparam int F_EXP_LSB = 12;
    localparam int F_FCH_LSB = 16;
    localparam int F_CH_LSB = 2;
    localparam int F_EXT = 4;
    localparam int F_BASE_LSB = 8;

    // Limits and resets; gauge units 1e-10 torr, reference units 1e-7 torr
    localparam logic [8:0] UFAC_RST = 9'h00A;
    localparam logic [8:0] UFAC_MIN = 9'h001;
    localparam logic [8:0] UFAC_MAX = 9'h1F4;
    localparam logic [8:0] DELAY_RST = 9'h003;
    localparam logic [8:0] DELAY_MIN = 9'h003;
    localparam logic [8:0] DELAY_MAX = 9'h12C;
    localparam logic [31:0] PROT_MIN = 32'h0001_86A0;
    localparam logic [31:0] PROT_MAX = 32'h05F5_E100;
    localparam logic [31:0] PROT_RST = 32'h02FA_F080;
    localparam logic [31:0] SP_MIN = 32'h0000_0002;
    localparam logic [31:0] SP_MAX = 32'h02FA_F080;
    localparam logic [31:0] SP_RST = 32'h0000_2710;
    localparam logic [31:0] HYST_RST = 32'h0000_3A98;
    localparam logic [31:0] FAST_RST = 32'h0001_86A0;
    localparam logic [31:0] CTL_PR_MIN = 32'h0000_1388;
    localparam logic [31:0] CTL_CP_MIN = 32'h0000_4E20;
    localparam logic [31:0] CTL_STD_MAX = 32'h0001_86A0;
    localparam logic [31:0] CTL_CM_MAX = 32'h0003_0D40;
    localparam logic [31:0] CTL_EXT_MAX = 32'h0090_F560;
    localparam logic [31:0] CTL_RST = 32'h0000_C350;
    localparam logic [31:0] CM_MIN_PERMILLE = 32'h0000_0002;
    localparam logic [31:0] FAST_REARM_PCT = 32'h0000_0055;
    localparam logic [7:0] RMODE_RST = 8'hAA;
    localparam logic [31:0] DISP_WAIT = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {RM_ON, RM_OFF, RM_CMP} igsc_rmode_t;
    typedef enum logic [1:0] {GAS_N2, GAS_AR, GAS_HE} igsc_gas_t;
    typedef enum logic [1:0] {POL_OFF, POL_AUTO, POL_SAFE} igsc_pol_t;
    typedef enum logic [1:0] {REF_THERMAL, REF_CONVECT, REF_DIAPHRAGM} igsc_reftype_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } igsc_ahb_in_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } igsc_ahb_out_t;

    typedef struct packed {
        logic [31:0] pressure;
        logic [1:0] gtype;
        logic [31:0] full_scale;
    } igsc_ref_t;

endpackage

// [hdl/igsc_top.sv]
// Ion gauge channel setpoint, protect, reference control and fast relay logic.
// Assumes gauge and reference readings come from logic on clk_sys; the
// reference-ok and fast comparator inputs are pins and are synchronised.
// Function
// [R1] Gas choice N2, Ar, He; N2 default
// [R2] User factor 0.1 to 50, default 1.0
// [R3] Relays off until 3-300 s delay expires
// [R4] Show waiting instead of pressure during delay
// [R5] Fast relay trips, re-arms 15% below
// [R6] Fast path within 3 ms; default 1e-5
// [R7] Protect threshold switches high voltage off
// [R8] Protect trip disables auto; manual restart only
// [R9] Four relays per slot, by slot number
// [R10] Relay modes forced on, off, compare
// [R11] Comparison direction fixed at below
// [R12] Relay setpoint only 2e-10 to 5e-3
// [R13] Setpoint write sets hysteresis 1.5 times
// [R14] Hysteresis below 1.1 times is clamped
// [R15] Control threshold limits per reference type
// [R16] Limit extension raises upper bound 0.95
// [R17] Reference loss switches gauge off
// [R18] Policy enable needs valid reference channel
// [R19] Auto policy switches on and off
// [R20] Safe policy only switches off automatically
// [R21] Off policy: manual commands only
// [R22] Fast threshold loaded by channel command
// [R23] Compare activates when pressure below setpoint
// [R24] Compare releases above hysteresis level
module igsc_top
    import igsc_pkg::*;
#(
    parameter int unsigned CYC_PER_S = CLK_HZ,
    parameter int unsigned SLOT = 0,
    parameter logic [3:0] FAST_CH = 4'h1,
    parameter logic [3:0] REF_CH_VALID = 4'hE,
    parameter logic [7:0] GAS_AR_FAC = 8'h0A,
    parameter logic [7:0] GAS_HE_FAC = 8'h0A
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire igsc_pkg::igsc_ahb_in_t ahb_i,
    output igsc_pkg::igsc_ahb_out_t ahb_o,
    input wire logic [31:0] ion_pressure,
    input wire igsc_pkg::igsc_ref_t ref_i,
    input wire logic ref_ok_pin,
    input wire logic fast_cmp_pin,
    output logic hv_on,
    output logic [3:0] relay,
    output logic fast_relay,
    output logic [31:0] fast_dac,
    output logic waiting,
    output logic [31:0] pressure_disp
);
    import igsc_pkg::*;

    typedef struct packed {
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic rd_wait;
        logic [31:0] hrdata;
        logic [1:0] gas;
        logic [8:0] ufac;
        logic [8:0] delay;
        logic [31:0] prot;
        logic [31:0] fast_thr;
        logic [1:0] policy;
        logic [1:0] ref_ch;
        logic ext;
        logic [31:0] ctl;
        logic [3:0][31:0] sp;
        logic [3:0][31:0] hyst;
        logic [7:0] rmode;
        logic [3:0] cmp;
        logic [3:0] relay;
        logic hv;
        logic hv_prev;
        logic inhibit;
        logic [31:0] sec_cnt;
        logic [8:0] secs;
        logic done;
        logic [31:0] disp;
        logic ok_s1;
        logic ok_s2;
        logic fc_s1;
        logic fc_s2;
        logic energ;
        logic [31:0] dac;
    } igsc_state_t;

    localparam igsc_state_t ST_RST = '{ufac: UFAC_RST, delay: DELAY_RST, prot: PROT_RST,
        fast_thr: FAST_RST, ctl: CTL_RST, sp: {4{SP_RST}}, hyst: {4{HYST_RST}},
        rmode: RMODE_RST, energ: 1'b1, dac: FAST_RST, default: '0};
    localparam logic [31:0] SEC_LAST = 32'(CYC_PER_S - 1);
    localparam logic [7:0] RELAY_BASE = 8'(SLOT * 4 + 1);

    igsc_state_t s_q;
    igsc_state_t s_d;
    logic [31:0] p_corr;
    logic wr;
    logic man_on;
    logic man_off;

    // Gas and user factor applied to the raw reading, both in tenths
    function automatic logic [31:0] gas_corr(input logic [31:0] raw, input logic [1:0] g,
                                             input logic [8:0] uf);
        logic [7:0] gf;
        logic [63:0] prod;
        gf = (g == GAS_AR) ? GAS_AR_FAC : (g == GAS_HE) ? GAS_HE_FAC : 8'h0A;
        prod = 64'(raw) * 64'(gf) * 64'(uf) / 64'd100;
        return (prod[63:32] != 32'h0) ? 32'hFFFF_FFFF : prod[31:0];
    endfunction

    // d.dd mantissa and exponent to gauge units; out-of-range or overflowing gives zero
    function automatic logic [31:0] mant_exp(input logic [9:0] m, input logic [3:0] e);
        logic [31:0] mv;
        mv = 32'(m);
        if (m < 10'd100 || m > 10'd999 || e < 4'h2) begin
            return 32'h0;
        end
        unique case (e)
            4'h0: return mv * 32'd100_000_000;
            4'h1: return mv * 32'd10_000_000;
            4'h2: return mv * 32'd1_000_000;
            4'h3: return mv * 32'd100_000;
            4'h4: return mv * 32'd10_000;
            4'h5: return mv * 32'd1_000;
            4'h6: return mv * 32'd100;
            4'h7: return mv * 32'd10;
            4'h8: return mv;
            4'h9: return mv / 32'd10;
            4'hA: return mv / 32'd100;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] rd_mux(input igsc_state_t s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a >= A_SP0 && a < A_RMODE) begin
            v = a[2] ? s.hyst[a[4:3]] : s.sp[a[4:3]];
        end else begin
            unique case (a)
                A_GAS: v = {30'h0, s.gas};
                A_UFAC: v = {23'h0, s.ufac};
                A_DELAY: v = {23'h0, s.delay};
                A_PROT: v = s.prot;
                A_FAST: v = s.fast_thr;
                A_CTL: v = {27'h0, s.ext, s.ref_ch, s.policy};
                A_CTLSP: v = s.ctl;
                A_HV: v = {23'h0, s.relay, s.energ, s.done, waiting, s.inhibit, s.hv};
                A_RMODE: v = {16'h0, RELAY_BASE, s.rmode};
                default: v = 32'h0;
            endcase
        end
        return v;
    endfunction

    assign p_corr = gas_corr(ion_pressure, s_q.gas, s_q.ufac);
    assign wr = s_q.dp_valid && s_q.dp_write;
    assign man_on = wr && s_q.dp_addr == A_HV && ahb_i.hwdata[0];
    assign man_off = wr && s_q.dp_addr == A_HV && ahb_i.hwdata[1];

    always_comb begin
        logic [31:0] w;
        logic [1:0] ri;
        logic [35:0] hmin;
        logic [31:0] cmin;
        logic [31:0] cmax;
        logic [1:0] npol;
        logic [1:0] nch;
        w = ahb_i.hwdata;
        ri = s_q.dp_addr[4:3];
        hmin = 36'(s_q.sp[ri]) * 36'd11 / 36'd10;
        cmin = CTL_PR_MIN;
        cmax = CTL_STD_MAX;
        npol = w[1:0];
        nch = w[F_CH_LSB +: 2];
        s_d = s_q;

        // Bus slave: reads take one wait state, writes none
        s_d.rd_wait = 1'b0;
        if (s_q.dp_valid && !s_q.dp_write && !s_q.rd_wait) begin
            s_d.hrdata = rd_mux(s_q, s_q.dp_addr);
            s_d.rd_wait = 1'b1;
        end
        if (ahb_o.hreadyout) begin
            s_d.dp_valid = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
            s_d.dp_write = ahb_i.hwrite;
            s_d.dp_addr = ahb_i.haddr[7:0];
        end

        // Reference type bounds on the control threshold
        unique case (ref_i.gtype)
            REF_CONVECT: cmin = CTL_CP_MIN; // [R15]
            REF_DIAPHRAGM: begin
                cmin = 32'(64'(ref_i.full_scale) * 64'(CM_MIN_PERMILLE) / 64'd1000); // [R15]
                cmax = CTL_CM_MAX;
            end
            default: cmin = CTL_PR_MIN;
        endcase
        if (s_q.ext) begin
            cmax = CTL_EXT_MAX; // [R16]
        end

        if (wr) begin
            if (s_q.dp_addr == A_GAS && w[1:0] <= GAS_HE) begin
                s_d.gas = w[1:0]; // [R1]
            end
            if (s_q.dp_addr == A_UFAC && w[8:0] >= UFAC_MIN && w[8:0] <= UFAC_MAX && w[31:9] == '0) begin
                s_d.ufac = w[8:0]; // [R2]
            end
            if (s_q.dp_addr == A_DELAY && w[8:0] >= DELAY_MIN && w[8:0] <= DELAY_MAX && w[31:9] == '0) begin
                s_d.delay = w[8:0]; // [R3]
            end
            if (s_q.dp_addr == A_PROT && w >= PROT_MIN && w <= PROT_MAX) begin
                s_d.prot = w; // [R7]
            end
            if (s_q.dp_addr == A_FAST && w[F_FCH_LSB +: 4] == FAST_CH
                && mant_exp(w[F_MANT_LSB +: 10], w[F_EXP_LSB +: 4]) != 32'h0) begin
                s_d.fast_thr = mant_exp(w[F_MANT_LSB +: 10], w[F_EXP_LSB +: 4]); // [R22]
            end
            if (s_q.dp_addr == A_CTL && npol <= POL_SAFE
                && (npol == POL_OFF || (nch != 2'h0 && REF_CH_VALID[nch]))) begin
                s_d.policy = npol; // [R18]
                s_d.ref_ch = nch;
            end
            if (s_q.dp_addr == A_CTL && w[F_EXT]) begin
                s_d.ext = 1'b1; // [R16]
            end
            if (s_q.dp_addr == A_CTLSP && w >= cmin && w <= cmax) begin
                s_d.ctl = w; // [R15]
            end
            if (s_q.dp_addr >= A_SP0 && s_q.dp_addr < A_RMODE) begin
                if (!s_q.dp_addr[2] && w >= SP_MIN && w <= SP_MAX) begin
                    s_d.sp[ri] = w; // [R12]
                    s_d.hyst[ri] = w + (w >> 1); // [R13]
                end else if (s_q.dp_addr[2]) begin
                    s_d.hyst[ri] = (36'(w) < hmin) ? hmin[31:0] : w; // [R14]
                end
            end
            if (s_q.dp_addr == A_RMODE) begin
                for (int i = 0; i < 4; i++) begin
                    if (w[2*i +: 2] <= RM_CMP) begin
                        s_d.rmode[2*i +: 2] = w[2*i +: 2]; // [R10]
                    end
                end
            end
        end

        // Pin synchronisers
        s_d.ok_s1 = ref_ok_pin;
        s_d.ok_s2 = s_q.ok_s1;
        s_d.fc_s1 = fast_cmp_pin;
        s_d.fc_s2 = s_q.fc_s1;

        // High voltage control, later steps take priority
        if (s_q.policy == POL_AUTO && !s_q.inhibit && s_q.ok_s2) begin
            s_d.hv = ref_i.pressure < s_q.ctl; // [R19]
        end
        if (s_q.policy == POL_SAFE && ref_i.pressure >= s_q.ctl) begin
            s_d.hv = 1'b0; // [R20]
        end
        if (s_q.policy != POL_OFF && !s_q.ok_s2) begin
            s_d.hv = 1'b0; // [R17] [R21]
        end
        if (man_on) begin
            s_d.hv = 1'b1; // [R8]
            s_d.inhibit = 1'b0;
        end
        if (man_off) begin
            s_d.hv = 1'b0;
        end
        if (s_q.hv && p_corr >= s_q.prot) begin
            s_d.hv = 1'b0; // [R7]
            s_d.inhibit = 1'b1; // [R8]
        end
        s_d.hv_prev = s_q.hv;

        // Start-up relay delay in whole seconds
        if (!s_q.hv || !s_q.hv_prev) begin
            s_d.sec_cnt = 32'h0;
            s_d.secs = 9'h0;
            s_d.done = 1'b0;
        end else if (!s_q.done) begin
            s_d.sec_cnt = s_q.sec_cnt + 32'h1;
            if (s_q.sec_cnt == SEC_LAST) begin
                s_d.sec_cnt = 32'h0;
                s_d.secs = s_q.secs + 9'h1;
                s_d.done = (s_q.secs + 9'h1) >= s_q.delay; // [R3]
            end
        end
        s_d.disp = (s_q.hv && !s_q.done) ? DISP_WAIT : p_corr; // [R4]

        // Setpoint relays, direction always below
        for (int i = 0; i < 4; i++) begin
            if (p_corr < s_q.sp[i]) begin
                s_d.cmp[i] = 1'b1; // [R11] [R23]
            end else if (p_corr > s_q.hyst[i]) begin
                s_d.cmp[i] = 1'b0; // [R24]
            end
            s_d.relay[i] = s_q.done && (s_q.rmode[2*i +: 2] == RM_ON
                || (s_q.rmode[2*i +: 2] == RM_CMP && s_q.cmp[i])); // [R3] [R10] [R9]
        end

        // Fast relay: trip above threshold, re-arm 15% below it
        if (s_q.energ && s_q.fc_s2) begin
            s_d.energ = 1'b0; // [R5] [R6]
        end else if (!s_q.energ && !s_q.fc_s2) begin
            s_d.energ = 1'b1; // [R5]
        end
        s_d.dac = s_d.energ ? s_d.fast_thr
            : 32'(64'(s_d.fast_thr) * 64'(FAST_REARM_PCT) / 64'd100); // [R5]
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign ahb_o.hreadyout = !(s_q.dp_valid && !s_q.dp_write && !s_q.rd_wait);
    assign ahb_o.hresp = 1'b0;
    assign ahb_o.hrdata = s_q.hrdata;
    assign hv_on = s_q.hv;
    assign relay = s_q.relay;
    assign fast_relay = s_q.energ;
    assign fast_dac = s_q.dac;
    assign waiting = s_q.hv && !s_q.done;
    assign pressure_disp = s_q.disp;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_hv_start;
        !hv_on ##1 hv_on;
    endsequence

    property p_relay_hold;
        !s_q.done |=> relay == 4'h0;
    endproperty
    a_relay_hold: assert property (p_relay_hold) else $error("relay active before delay"); // [R3]

    property p_wait;
        s_hv_start |-> waiting ##1 (waiting || !hv_on);
    endproperty
    a_wait: assert property (p_wait) else $error("no wait indication at start"); // [R4]

    property p_fast_resp;
        fast_relay && fast_cmp_pin ##1 fast_cmp_pin ##1 fast_cmp_pin |=> !fast_relay;
    endproperty
    a_fast_resp: assert property (p_fast_resp) else $error("fast relay slow to trip"); // [R6]

    property p_fast_rearm;
        !fast_relay |-> fast_dac == 32'(64'(s_q.fast_thr) * 64'd85 / 64'd100);
    endproperty
    a_fast_rearm: assert property (p_fast_rearm) else $error("fast re-arm level wrong"); // [R5]

    property p_protect;
        hv_on && p_corr >= s_q.prot |=> !hv_on && s_q.inhibit;
    endproperty
    a_protect: assert property (p_protect) else $error("protect did not trip"); // [R7]

    property p_inhibit;
        s_q.inhibit && !hv_on && !man_on |=> !hv_on;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("auto restart after protect"); // [R8]

    property p_below;
        s_q.done && hv_on && s_q.rmode[1:0] == 2'h2 && p_corr < s_q.sp[0]
            ##1 s_q.done && s_q.rmode[1:0] == 2'h2 |=> relay[0];
    endproperty
    a_below: assert property (p_below) else $error("compare relay not active"); // [R23]

    property p_hyst_auto;
        wr && s_q.dp_addr == A_SP0 && ahb_i.hwdata >= SP_MIN && ahb_i.hwdata <= SP_MAX
            |=> s_q.hyst[0] == $past(ahb_i.hwdata) + ($past(ahb_i.hwdata) >> 1);
    endproperty
    a_hyst_auto: assert property (p_hyst_auto) else $error("hysteresis not 1.5 times"); // [R13]

    property p_safe;
        s_q.policy == 2'h2 && !hv_on && !man_on |=> !hv_on;
    endproperty
    a_safe: assert property (p_safe) else $error("safe policy switched on"); // [R20]

    property p_ref_loss;
        s_q.policy != 2'h0 && !s_q.ok_s2 && !man_on |=> !hv_on;
    endproperty
    a_ref_loss: assert property (p_ref_loss) else $error("gauge on with reference lost"); // [R17]

endmodule

// [verif/igsc_gauge_model.sv]
// Behavioural cold cathode gauge, reference gauge and fast comparator.
// Assumes the bench sets target readings; outputs change just after clk_sys edges.
module igsc_gauge_model
    import igsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] gauge_level,
    input wire logic [31:0] ref_level,
    input wire logic [1:0] ref_kind,
    input wire logic [31:0] ref_span,
    input wire logic ref_power,
    input wire logic [31:0] fast_dac,
    output logic [31:0] ion_pressure,
    output igsc_pkg::igsc_ref_t ref_i,
    output logic ref_ok_pin,
    output logic fast_cmp_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ion_pressure = 32'h0;
        ref_i = '0;
        ref_ok_pin = 1'b0;
        fast_cmp_pin = 1'b0;
    end
    always @(posedge clk_sys) begin
        ion_pressure <= gauge_level;
        ref_i.gtype <= ref_kind;
        ref_i.full_scale <= ref_span;
        // Unpowered reference gives no stable reading
        ref_i.pressure <= ref_power ? ref_level : ~ref_i.pressure;
        ref_ok_pin <= ref_power;
        // Buffered gauge level against threshold DAC
        fast_cmp_pin <= gauge_level > fast_dac;
    end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the ion gauge setpoint and control block.
// Assumes igsc_pkg and the gauge model are compiled first; one 40 MHz clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import igsc_pkg::*;
    logic clk_sys, sys_rst, ref_power, rdy_n, ref_ok_pin, fast_cmp_pin, hv_on, fast_relay, waiting;
    logic [31:0] gauge_level, ref_level, ref_span, rd_n, disp_n, dac_n, ion_pressure, fast_dac, pressure_disp, r;
    logic [1:0] ref_kind;
    logic [3:0] relay;
    logic [6:0] pins_n;
    igsc_ahb_in_t bus, ahb_in;
    igsc_ahb_out_t ahb_o;
    igsc_ref_t ref_i;
    int n_mismatch = 0;
    int checks = 0;
    always_comb begin
        ahb_in = bus;
        ahb_in.hready = ahb_o.hreadyout;
    end
    // Snapshot of settled outputs ahead of each rising edge
    always @(negedge clk_sys) begin
        rdy_n = ahb_o.hreadyout;
        rd_n = ahb_o.hrdata;
        pins_n = {hv_on, relay, fast_relay, waiting};
        disp_n = pressure_disp;
        dac_n = fast_dac;
    end
    igsc_top #(.CYC_PER_S(10)) i_igsc_top (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ahb_i(ahb_in),
        .ahb_o(ahb_o),
        .ion_pressure(ion_pressure),
        .ref_i(ref_i),
        .ref_ok_pin(ref_ok_pin),
        .fast_cmp_pin(fast_cmp_pin),
        .hv_on(hv_on),
        .relay(relay),
        .fast_relay(fast_relay),
        .fast_dac(fast_dac),
        .waiting(waiting),
        .pressure_disp(pressure_disp)
    );
    igsc_gauge_model i_igsc_gauge_model (
        .clk_sys(clk_sys),
        .gauge_level(gauge_level),
        .ref_level(ref_level),
        .ref_kind(ref_kind),
        .ref_span(ref_span),
        .ref_power(ref_power),
        .fast_dac(fast_dac),
        .ion_pressure(ion_pressure),
        .ref_i(ref_i),
        .ref_ok_pin(ref_ok_pin),
        .fast_cmp_pin(fast_cmp_pin)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        bus.hsel <= 1'b1;
        bus.haddr <= {24'h0, a};
        bus.htrans <= 2'h2;
        bus.hwrite <= w;
        bus.hsize <= 3'h2;
        do @(posedge clk_sys); while (rdy_n !== 1'b1);
        bus.hsel <= 1'b0;
        bus.htrans <= 2'h0;
        bus.hwdata <= d;
        do @(posedge clk_sys); while (rdy_n !== 1'b1);
        q = rd_n;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), e, r);
        chk("hresp", 32'h0, {31'h0, ahb_o.hresp});
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        wr(a, d);
        rdc(a, e);
    endtask
    task automatic hv(input logic e);
        chk("hv_on", {31'h0, e}, {31'h0, pins_n[6]});
    endtask
    task automatic rel(input logic [3:0] e);
        chk("relay", {28'h0, e}, {28'h0, pins_n[5:2]});
    endtask
    task automatic fr(input logic e);
        chk("fast_relay", {31'h0, e}, {31'h0, pins_n[1]});
    endtask
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        $display("Error watchdog expired");
        final_report;
    end
    initial begin
        sys_rst = 1'b1;
        bus = '0;
        gauge_level = 32'h1F4;
        ref_level = 32'h186A0;
        ref_span = 32'h1E8480;
        ref_kind = 2'h0;
        ref_power = 1'b1;
        tick(10);
        sys_rst <= 1'b0;
        tick(2);
        chk("pins", 7'h02, pins_n);
        chk("fast_dac", FAST_RST, dac_n);
        rdc(A_GAS, 32'h0);
        rdc(A_UFAC, {23'h0, UFAC_RST});
        rdc(A_DELAY, {23'h0, DELAY_RST});
        rdc(A_PROT, PROT_RST);
        rdc(A_FAST, FAST_RST);
        rdc(A_CTLSP, CTL_RST);
        rdc(A_SP0 + 8'h18, SP_RST);
        rdc(A_SP0 + 8'h1C, HYST_RST);
        rdc(A_RMODE, {16'h0, 8'h01, RMODE_RST});
        rdc(8'h48, 32'h0);
        wrc(A_GAS, 32'h1, 32'h1);
        wrc(A_GAS, 32'h2, 32'h2);
        wrc(A_GAS, 32'h3, 32'h2);
        wrc(A_GAS, 32'h0, 32'h0);
        wrc(A_UFAC, 32'h0, 32'hA);
        wrc(A_UFAC, 32'h1F5, 32'hA);
        wrc(A_UFAC, 32'h1F4, 32'h1F4);
        wrc(A_UFAC, 32'h1, 32'h1);
        wrc(A_UFAC, 32'hA, 32'hA);
        wrc(A_DELAY, 32'h2, 32'h3);
        wrc(A_DELAY, 32'h12D, 32'h3);
        wrc(A_DELAY, 32'h12C, 32'h12C);
        wrc(A_DELAY, 32'h3, 32'h3);
        wrc(A_PROT, PROT_MIN - 32'h1, PROT_RST);
        wrc(A_PROT, PROT_MAX + 32'h1, PROT_RST);
        wrc(A_SP0, 32'h1, SP_RST);
        wrc(A_SP0, SP_MAX + 32'h1, SP_RST);
        wrc(A_SP0, SP_MIN, SP_MIN);
        wrc(A_SP0, SP_MAX, SP_MAX);
        rdc(A_SP0 + 8'h4, SP_MAX + (SP_MAX >> 1));
        wrc(A_SP0, 32'h3E8, 32'h3E8);
        rdc(A_SP0 + 8'h4, 32'h5DC);
        wrc(A_SP0 + 8'h4, 32'h3E8, 32'h44C);
        wrc(A_SP0 + 8'h4, 32'h5DC, 32'h5DC);
        wrc(A_CTLSP, CTL_PR_MIN - 32'h1, CTL_RST);
        wrc(A_CTLSP, CTL_PR_MIN, CTL_PR_MIN);
        wrc(A_CTLSP, CTL_STD_MAX + 32'h1, CTL_PR_MIN);
        ref_kind <= 2'h1;
        wrc(A_CTLSP, CTL_CP_MIN - 32'h1, CTL_PR_MIN);
        wrc(A_CTLSP, CTL_CP_MIN, CTL_CP_MIN);
        ref_kind <= 2'h2;
        wrc(A_CTLSP, 32'hF9F, CTL_CP_MIN);
        wrc(A_CTLSP, 32'hFA0, 32'hFA0);
        wrc(A_CTLSP, CTL_CM_MAX + 32'h1, 32'hFA0);
        wr(A_CTL, 32'h10);
        wrc(A_CTLSP, CTL_EXT_MAX, CTL_EXT_MAX);
        wrc(A_CTLSP, CTL_EXT_MAX + 32'h1, CTL_EXT_MAX);
        ref_kind <= 2'h0;
        wrc(A_CTLSP, CTL_RST, CTL_RST);
        ref_level <= 32'h2710;
        wr(A_CTL, 32'h1);
        tick(8);
        hv(1'b0);
        wr(A_CTL, 32'h4);
        tick(8);
        hv(1'b0);
        wr(A_RMODE, 32'hD2);
        wr(A_HV, 32'h1);
        tick(20);
        hv(1'b1);
        chk("waiting", 32'h1, {31'h0, pins_n[0]});
        chk("pressure_disp", DISP_WAIT, disp_n);
        rel(4'h0);
        tick(20);
        chk("waiting", 32'h0, {31'h0, pins_n[0]});
        chk("pressure_disp", 32'h1F4, disp_n);
        rel(4'hB);
        ref_level <= 32'h186A0;
        gauge_level <= 32'h4B0;
        tick(8);
        hv(1'b1);
        rel(4'hB);
        gauge_level <= 32'h640;
        tick(8);
        rel(4'hA);
        gauge_level <= 32'h1F4;
        tick(8);
        rel(4'hB);
        wr(A_CTL, 32'h5);
        tick(8);
        hv(1'b0);
        ref_level <= 32'h2710;
        tick(8);
        hv(1'b1);
        ref_power <= 1'b0;
        tick(10);
        hv(1'b0);
        ref_power <= 1'b1;
        tick(10);
        hv(1'b1);
        wr(A_CTL, 32'h6);
        ref_level <= 32'h186A0;
        tick(8);
        hv(1'b0);
        ref_level <= 32'h2710;
        tick(8);
        hv(1'b0);
        wr(A_HV, 32'h1);
        tick(8);
        hv(1'b1);
        wr(A_CTL, 32'h5);
        wr(A_PROT, PROT_MIN);
        gauge_level <= 32'h30D40;
        tick(8);
        hv(1'b0);
        xfer(1'b0, A_HV, 32'h0, r);
        chk("inhibit", 32'h1, {31'h0, r[1]});
        gauge_level <= 32'h1F4;
        tick(10);
        hv(1'b0);
        wr(A_HV, 32'h1);
        tick(8);
        hv(1'b1);
        wr(A_CTL, 32'h0);
        wr(A_HV, 32'h2);
        wr(A_PROT, PROT_RST);
        tick(8);
        hv(1'b0);
        wrc(A_FAST, 32'h151F4, 32'h7A120);
        wrc(A_FAST, 32'h341F4, 32'h7A120);
        chk("fast_dac", 32'h7A120, dac_n);
        fr(1'b1);
        gauge_level <= 32'h7A121;
        tick(12);
        fr(1'b0);
        chk("fast_dac", 32'h67C28, dac_n);
        gauge_level <= 32'h6B6C0;
        tick(12);
        fr(1'b0);
        gauge_level <= 32'h61A80;
        tick(12);
        fr(1'b1);
        final_report;
    end
endmodule
